// ===== hdl/aor_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// depth must be a power of two: wrap uses the extra pointer bit
module aor_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,       // block clock
	input  wire logic             reset,     // sync, active high
	input  wire logic             in_valid,  // word offered
	output logic                  in_ready,  // room for a word
	input  wire logic [WIDTH-1:0] in_data,   // word in
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // drain takes word
	output logic      [WIDTH-1:0] out_data   // head word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire              empty = (wr_q == rd_q);
	wire              push  = in_valid && !full;
	wire              pop   = out_ready && !empty;

	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_q[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			wr_q <= push ? wr_q + 1'b1 : wr_q;
			rd_q <= pop ? rd_q + 1'b1 : rd_q;
		end
	end
endmodule // aor_fifo
`default_nettype wire

// ===== hdl/aor_top.sv
`timescale 1ns/1ps
`default_nettype none
module aor_top #(
	parameter int FIFO_DEPTH = aor_pkg::FIFO_DEPTH
) (
	input  wire logic                       ref_clk,              // block clock, 125 MHz
	input  wire logic                       reset,                // sync, active high
	input  wire logic                       sample_clock_input,   // encode clock pin
	input  wire logic                       scramble_enable,      // pin, high scrambles
	input  wire logic                       dither_enable,        // pin, high dithers
	input  wire logic                       demux_mode,           // pin, high = two buses
	input  wire logic                       output_hold,          // pin, downstream stall
	input  wire logic [aor_pkg::DATA_W-1:0] raw_result,           // core result, ref_clk
	input  wire logic                       raw_overrange,        // core range flag
	output logic      [aor_pkg::DATA_W-1:0] dither_value,         // to dither converter
	output logic      [aor_pkg::DATA_W-1:0] data_a,               // bus A
	output logic      [aor_pkg::DATA_W-1:0] data_b,               // bus B, demux only
	output logic                            overrange_flag_a,     // bus A range flag
	output logic                            overrange_flag_b,     // bus B range flag
	output logic                            forwarded_clock_true, // forwarded clock
	output logic                            forwarded_clock_comp, // its complement
	output logic                            sample_dropped        // pulse, fifo was full
);
	localparam int DW = aor_pkg::DATA_W;
	localparam int WW = $bits(aor_pkg::aor_word_type);

	// ---------------------------------------------
	// scrambling
	// ---------------------------------------------
	function automatic logic [DW-1:0] scramble(input logic [DW-1:0] d, input logic en);
		scramble = en ? {d[DW-1:1] ^ {(DW-1){d[0]}}, d[0]} : d;
	endfunction

	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	logic [aor_pkg::PIN_COUNT-1:0] meta_q;
	logic [aor_pkg::PIN_COUNT-1:0] sync_q;
	logic                          enc_last_q;
	wire  [aor_pkg::PIN_COUNT-1:0] pin_vec = {output_hold, demux_mode, dither_enable,
	                                          scramble_enable, sample_clock_input};

	always_ff @(posedge ref_clk)
	begin
		meta_q     <= reset ? '0 : pin_vec;
		sync_q     <= reset ? '0 : meta_q;
		enc_last_q <= reset ? 1'b0 : sync_q[aor_pkg::PIN_ENC];
	end

	wire enc_s    = sync_q[aor_pkg::PIN_ENC];
	wire scr_s    = sync_q[aor_pkg::PIN_SCRAMBLE];
	wire dith_s   = sync_q[aor_pkg::PIN_DITHER];
	wire demux_s  = sync_q[aor_pkg::PIN_DEMUX];
	wire hold_s   = sync_q[aor_pkg::PIN_HOLD];
	wire enc_rise = enc_s && !enc_last_q;
	wire enc_fall = !enc_s && enc_last_q;

	// ---------------------------------------------
	// dither generator and subtraction
	// ---------------------------------------------
	// dither_value_q is what the converter sees during the current sample,
	// so the result taken at the next encode rise is paired with it
	logic [aor_pkg::LFSR_W-1:0] lfsr_q;
	logic [DW-1:0]              dither_value_q;
	logic                       sample_dropped_q;
	wire  [aor_pkg::LFSR_W-1:0] lfsr_d = {lfsr_q[aor_pkg::LFSR_W-2:0],
	                                      lfsr_q[aor_pkg::LFSR_TAP_A] ^ lfsr_q[aor_pkg::LFSR_TAP_B]};
	wire  [DW-1:0]              dither_d = dith_s ? lfsr_d[DW-1:0] : '0;
	aor_pkg::aor_word_type      push_word;
	wire                        push_ready;

	assign push_word.data = raw_result - dither_value_q;
	assign push_word.ovr  = raw_overrange;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			lfsr_q           <= aor_pkg::LFSR_SEED;
			dither_value_q   <= '0;
			sample_dropped_q <= 1'b0;
		end
		else
		begin
			lfsr_q           <= (enc_rise && dith_s) ? lfsr_d : lfsr_q;
			dither_value_q   <= enc_rise ? dither_d : dither_value_q;
			sample_dropped_q <= enc_rise && !push_ready;
		end
	end

	// ---------------------------------------------
	// output buffer
	// ---------------------------------------------
	// a held-off receiver fills the fifo; once full, new samples are lost
	// and flagged rather than overwriting words already queued
	wire [WW-1:0]          pop_bits;
	wire                   pop_valid;
	aor_pkg::aor_word_type pop_word;
	logic                  phase_q;
	logic                  pend_valid_q;
	wire                   pop_ok = enc_fall && !hold_s && pop_valid &&
	                                (!demux_s || !phase_q || pend_valid_q);

	assign pop_word = aor_pkg::aor_word_type'(pop_bits);

	aor_fifo #(
		.WIDTH (WW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (ref_clk),
		.reset     (reset),
		.in_valid  (enc_rise),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (pop_valid),
		.out_ready (pop_ok),
		.out_data  (pop_bits)
	);

	// ---------------------------------------------
	// output stage
	// ---------------------------------------------
	aor_pkg::aor_word_type pend_q;
	logic [DW-1:0]         data_a_q;
	logic [DW-1:0]         data_b_q;
	logic                  ovr_a_q;
	logic                  ovr_b_q;
	logic                  fwd_true_q;
	logic                  fwd_comp_q;
	wire                   load_a_full  = pop_ok && !demux_s;
	wire                   load_pend    = pop_ok && demux_s && !phase_q;
	wire                   load_ab      = pop_ok && demux_s && phase_q;
	wire                   fwd_true_full = enc_rise ? 1'b1 : (enc_fall ? 1'b0 : fwd_true_q);
	wire                   fwd_true_dmx  = enc_fall ? !phase_q : fwd_true_q;
	wire                   fwd_true_d    = demux_s ? fwd_true_dmx : fwd_true_full;
	wire [DW-1:0]          data_a_d = load_ab ? scramble(pend_q.data, scr_s) :
	                                  scramble(pop_word.data, scr_s);
	wire [DW-1:0]          data_b_d = scramble(pop_word.data, scr_s);

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			phase_q      <= 1'b0;
			pend_valid_q <= 1'b0;
			pend_q       <= '0;
		end
		else
		begin
			phase_q      <= demux_s ? (enc_fall ? !phase_q : phase_q) : 1'b0;
			pend_valid_q <= load_pend ? 1'b1 : ((enc_fall && phase_q) ? 1'b0 : pend_valid_q);
			pend_q       <= load_pend ? pop_word : pend_q;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			data_a_q   <= '0;
			data_b_q   <= '0;
			ovr_a_q    <= 1'b0;
			ovr_b_q    <= 1'b0;
			fwd_true_q <= 1'b0;
			fwd_comp_q <= 1'b1;
		end
		else
		begin
			data_a_q   <= (load_a_full || load_ab) ? data_a_d : data_a_q;
			ovr_a_q    <= load_a_full ? pop_word.ovr : (load_ab ? pend_q.ovr : ovr_a_q);
			data_b_q   <= load_ab ? data_b_d : data_b_q;
			ovr_b_q    <= load_ab ? pop_word.ovr : ovr_b_q;
			fwd_true_q <= fwd_true_d;
			fwd_comp_q <= !fwd_true_d;
		end
	end

	assign dither_value         = dither_value_q;
	assign data_a               = data_a_q;
	assign data_b               = data_b_q;
	assign overrange_flag_a     = ovr_a_q;
	assign overrange_flag_b     = ovr_b_q;
	assign forwarded_clock_true = fwd_true_q;
	assign forwarded_clock_comp = fwd_comp_q;
	assign sample_dropped       = sample_dropped_q;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	AST_SCRAMBLE_XOR: assert property (
		load_a_full && scr_s |=> data_a_q[DW-1:1] ==
			($past(pop_word.data[DW-1:1]) ^ {(DW-1){$past(pop_word.data[0])}}))
		else $error("scrambled bus A bits are not xor with lsb");

	AST_LSB_FLAG_KEPT: assert property (
		load_a_full |=> data_a_q[0] == $past(pop_word.data[0]) && ovr_a_q == $past(pop_word.ovr))
		else $error("lsb or overrange flag altered on bus A");

	AST_CLOCKS_COMPLEMENT: assert property (
		##1 fwd_comp_q != fwd_true_q)
		else $error("forwarded clocks are not complementary");

	AST_PASS_WHEN_OFF: assert property (
		load_a_full && !scr_s |=> data_a_q == $past(pop_word.data))
		else $error("bus A modified while scrambling off");

	AST_PASS_DEMUX_OFF: assert property (
		load_ab && !scr_s |=> data_b_q == $past(pop_word.data) && data_a_q == $past(pend_q.data))
		else $error("demux buses modified while scrambling off");

	AST_LFSR_ADVANCE: assert property (
		enc_rise && dith_s |=> lfsr_q != $past(lfsr_q) && lfsr_q != '0 &&
			dither_value_q == lfsr_q[DW-1:0])
		else $error("dither sequence did not advance");

	AST_DITHER_OFF_ZERO: assert property (
		enc_rise && !dith_s |=> dither_value_q == '0 && $stable(lfsr_q))
		else $error("dither active while not selected");

	AST_SUBTRACT: assert property (
		enc_rise |-> DW'(push_word.data + dither_value_q) == raw_result)
		else $error("queued result not corrected by dither value");

	AST_OVERRANGE: assert property (
		enc_rise && push_ready && raw_overrange |=> u_fifo.out_valid)
		else $error("overrange sample not queued");

	AST_DEMUX_FALL: assert property (
		demux_s && enc_fall && phase_q |=> !fwd_true_q && !phase_q)
		else $error("demux true clock did not fall with bus load");

	AST_DEMUX_RISE: assert property (
		demux_s && enc_fall && !phase_q |=> fwd_true_q && $stable(data_a_q) && $stable(data_b_q))
		else $error("demux buses changed on rising true clock");
endmodule // aor_top
`default_nettype wire

// ===== pkg/aor_pkg.sv
// Contract
// - With scrambling on, every data bit above the LSB leaves as that bit XORed with the LSB of its own word.
// - Scrambling never alters the LSB, the overrange flag or the forwarded clocks.
// - Scrambling is applied only while scramble_enable is high.
// - With dither on, a long pseudo-random sequence supplies the value sent to the dither converter.
// - The value that drove the dither converter for a sample is subtracted from that sample's result.
// - Dither stays off unless dither_enable selects it, so results are undithered by default.
// - The overrange flag is high for every result whose input was over or under range.
// - In demultiplexed mode both forwarded clocks run at half the encode rate and both buses are valid on the same edges.
`default_nettype none
package aor_pkg;
	localparam int          DATA_W        = 16;
	localparam int          LFSR_W        = 31;
	localparam int          LFSR_TAP_A    = 30;
	localparam int          LFSR_TAP_B    = 27;
	localparam logic [30:0] LFSR_SEED     = 31'h0000_0001;
	localparam int          FIFO_DEPTH    = 32;
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          PIN_COUNT     = 5;
	localparam int          PIN_ENC       = 0;
	localparam int          PIN_SCRAMBLE  = 1;
	localparam int          PIN_DITHER    = 2;
	localparam int          PIN_DEMUX     = 3;
	localparam int          PIN_HOLD      = 4;

	typedef struct packed {
		logic              ovr;
		logic [DATA_W-1:0] data;
	} aor_word_type;
endpackage
`default_nettype wire

// ===== sim/aor_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// downstream capture logic
// ----------------------------------------
module aor_rx_model (
	input  wire logic                       forwarded_clock_true, // capture clock
	input  wire logic                       demux_mode,           // two-bus capture
	input  wire logic [aor_pkg::DATA_W-1:0] data_a,               // bus A
	input  wire logic [aor_pkg::DATA_W-1:0] data_b,               // bus B
	input  wire logic                       overrange_flag_a,     // flag A
	input  wire logic                       overrange_flag_b      // flag B
);
	aor_pkg::aor_word_type got_q[$];
	logic [33:0]           last_q = '0;
	int                    rises  = 0;

	function automatic logic [aor_pkg::DATA_W-1:0] unscramble(input logic [aor_pkg::DATA_W-1:0] w);
		return w ^ {{(aor_pkg::DATA_W-1){w[0]}}, 1'b0};
	endfunction

	// an idle bus repeats its word, so only a new word counts as a capture
	always @(posedge forwarded_clock_true)
	begin
		rises++;
		if ({overrange_flag_a, data_a, overrange_flag_b, data_b} !== last_q)
		begin
			last_q = {overrange_flag_a, data_a, overrange_flag_b, data_b};
			got_q.push_back({overrange_flag_a, data_a});
			if (demux_mode)
				got_q.push_back({overrange_flag_b, data_b});
		end
	end
endmodule // aor_rx_model
`default_nettype wire

// ===== sim/aor_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module aor_top_tb_top;
	logic        ref_clk            = 1'b0;
	logic        reset              = 1'b1;
	logic        sample_clock_input = 1'b0;
	logic        scramble_enable    = 1'b0;
	logic        dither_enable      = 1'b0;
	logic        demux_mode         = 1'b0;
	logic        output_hold        = 1'b0;
	logic        raw_overrange      = 1'b0;
	logic [15:0] raw_result         = 16'h0000;
	logic [15:0] dither_value, data_a, data_b;
	logic        overrange_flag_a, overrange_flag_b, sample_dropped;
	logic        forwarded_clock_true, forwarded_clock_comp;
	int          errors = 0, checks_done = 0, cycles = 0, drops = 0;
	logic [17:0] exp_q[$];

	aor_top uut (
		.ref_clk, .reset, .sample_clock_input, .scramble_enable, .dither_enable,
		.demux_mode, .output_hold, .raw_result, .raw_overrange, .dither_value,
		.data_a, .data_b, .overrange_flag_a, .overrange_flag_b,
		.forwarded_clock_true, .forwarded_clock_comp, .sample_dropped
	);
	aor_rx_model rx (
		.forwarded_clock_true, .demux_mode, .data_a, .data_b,
		.overrange_flag_a, .overrange_flag_b
	);

	always #4 ref_clk = ~ref_clk;

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [16:0] expv, input logic [16:0] got);
		checks_done++;
		if (got !== expv)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, expv, got);
		end
	endtask

	always @(posedge ref_clk)
	begin
		cycles++;
		drops += (sample_dropped === 1'b1);
		if (reset === 1'b0)
			cmp("clock pair", 17'h00001, {16'h0000, forwarded_clock_comp ^ forwarded_clock_true});
		if (cycles == 4000)
		begin
			errors++;
			test_done();
		end
	end

	// one encode period of 20 cycles; the result is held across the whole high phase
	task automatic period(input logic [15:0] raw, input logic ovr, input logic hold, input logic keep);
		@(posedge ref_clk);
		sample_clock_input <= 1'b1;
		raw_result <= raw;
		raw_overrange <= ovr;
		output_hold <= hold;
		if (keep)
			exp_q.push_back({scramble_enable, ovr, raw - dither_value});
		repeat (10) @(posedge ref_clk);
		sample_clock_input <= 1'b0;
		repeat (9) @(posedge ref_clk);
	endtask

	task automatic check_rx();
		logic [17:0]           e;
		logic [15:0]           s;
		aor_pkg::aor_word_type g;
		while (rx.got_q.size() > 0)
		begin
			g = rx.got_q.pop_front();
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3ffff;
			s = e[17] ? {e[15:1] ^ {15{e[0]}}, e[0]} : e[15:0];
			cmp("wire word", {e[16], s}, g);
			if (e[17])
				cmp("unscrambled", e[16:0], {g.ovr, rx.unscramble(g.data)});
		end
	endtask

	task automatic t_plain();
		int r0 = rx.rises;
		for (int i = 0; i < 6; i++)
		begin
			period(16'h1235 + 16'(i * 16'h0102), i[0], 1'b0, 1'b1);
			cmp("dither idle", 17'h00000, {1'b0, dither_value});
		end
		cmp("rises", 17'(6), 17'(rx.rises - r0));
		check_rx();
	endtask

	task automatic t_scramble();
		@(posedge ref_clk);
		scramble_enable <= 1'b1;
		for (int i = 0; i < 6; i++)
			period(16'h8001 + 16'(i * 16'h1111), i == 2, 1'b0, 1'b1);
		check_rx();
	endtask

	task automatic t_dither();
		logic [15:0]                prev;
		logic [aor_pkg::LFSR_W-1:0] lfsr;
		// reference sequence; nothing advanced the generator since reset
		lfsr = aor_pkg::LFSR_SEED;
		@(posedge ref_clk);
		dither_enable <= 1'b1;
		scramble_enable <= 1'b0;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 6; i++)
		begin
			prev = dither_value;
			period(16'h7000 + 16'(i * 16'h0333), 1'b0, 1'b0, 1'b1);
			lfsr = {lfsr[aor_pkg::LFSR_W-2:0], lfsr[aor_pkg::LFSR_TAP_A] ^ lfsr[aor_pkg::LFSR_TAP_B]};
			cmp("dither_value", {1'b0, lfsr[15:0]}, {1'b0, dither_value});
			checks_done++;
			if (dither_value === prev)
			begin
				errors++;
				$display("ERROR dither_value expected new value seen %h", dither_value);
			end
		end
		dither_enable <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check_rx();
	endtask

	// stall the far side until the buffer refuses, then release it; one word in and one out per period keeps it from draining
	task automatic t_overflow();
		int d0 = drops;
		for (int i = 0; i < 34; i++)
			period(16'h4000 + 16'(i), 1'b0, i < 33, i < 32);
		cmp("dropped", 17'(2), 17'(drops - d0));
		for (int i = 0; i < 36; i++)
			period(16'h5000 + 16'(i), i == 7, 1'b0, 1'b1);
		check_rx();
	endtask

	task automatic t_demux();
		int r0;
		@(posedge ref_clk);
		reset <= 1'b1;
		demux_mode <= 1'b1;
		scramble_enable <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		exp_q.delete();
		rx.got_q.delete();
		rx.last_q = '0;
		repeat (3) @(posedge ref_clk);
		cmp("reset bus", 17'h00000, {overrange_flag_a, data_a});
		r0 = rx.rises;
		// second half of the run leaves scrambling off, so pairs pass untouched
		for (int i = 0; i < 8; i++)
		begin
			scramble_enable <= (i < 4);
			period(16'h2001 + 16'(i * 16'h0f0f), i == 3 || i == 4, 1'b0, 1'b1);
		end
		cmp("half rate", 17'(4), 17'(rx.rises - r0));
		check_rx();
	endtask

	initial
	begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
		t_plain();
		t_scramble();
		t_dither();
		t_overflow();
		t_demux();
		test_done();
	end
endmodule // aor_top_tb_top
`default_nettype wire
